// ===== doag_map.svh
`ifndef DOAG_MAP_SVH
`define DOAG_MAP_SVH

`define DOAG_AW        14
`define DOAG_DW        16
`define DOAG_PW        24
`define DOAG_XW        8
`define DOAG_NPTR      4

`define DOAG_KIND_IDX  2'h0
`define DOAG_KIND_MOD  2'h1
`define DOAG_KIND_LEN  2'h2

`define DOAG_OFS_GEN1  8'h00
`define DOAG_OFS_GEN2  8'h40
`define DOAG_OFS_CTRL  8'h80
`define DOAG_OFS_PX    8'h84
`define DOAG_OFS_STAT  8'h88

`define DOAG_CTRL_BREV 0
`define DOAG_RST_WORD  14'h0000
`define DOAG_RST_PX    8'h00

`endif

// ===== doag_pkg.sv
package doag_pkg;

  typedef logic [13:0] doag_addr_t;

  // one indirect access: pointer to use and modify register to apply
  typedef struct packed {
    logic       valid;
    logic [1:0] ptr;
    logic [1:0] mod;
  } doag_req_s;

  // software access to one generator register
  typedef struct packed {
    logic       en;
    logic [1:0] kind;
    logic [1:0] idx;
    doag_addr_t data;
  } doag_wr_s;

endpackage : doag_pkg

// ===== doag_agen.sv
`include "doag_map.svh"

module doag_agen #(
  parameter bit BITREV_OK = 1'b0
) (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire doag_pkg::doag_wr_s wr,
  input  wire doag_pkg::doag_req_s use_req,
  input  wire logic               bitrev_en,
  input  wire logic [1:0]         rd_kind,
  input  wire logic [1:0]         rd_idx,
  output doag_pkg::doag_addr_t    addr_out,
  output doag_pkg::doag_addr_t    rd_data
);

  doag_pkg::doag_addr_t idx_q  [`DOAG_NPTR];
  doag_pkg::doag_addr_t base_q [`DOAG_NPTR];
  doag_pkg::doag_addr_t mod_q  [`DOAG_NPTR];
  doag_pkg::doag_addr_t len_q  [`DOAG_NPTR];
  doag_pkg::doag_addr_t idx_d;
  doag_pkg::doag_addr_t cur;

  assign cur = idx_q[use_req.ptr];

  // post-modify; offset is kept signed so a negative step can wrap upward
  always_comb begin
    logic [15:0] off;
    logic [15:0] step;
    logic [15:0] noff;
    logic [15:0] len;
    off  = {2'h0, cur - base_q[use_req.ptr]};
    step = {{2{mod_q[use_req.mod][13]}}, mod_q[use_req.mod]};
    len  = {2'h0, len_q[use_req.ptr]};
    noff = off + step;
    if (len_q[use_req.ptr] == `DOAG_RST_WORD) begin
      idx_d = cur + mod_q[use_req.mod]; // [R12]
    end else begin
      if (noff[15]) begin
        noff = noff + len; // [R3]
      end else if (noff >= len) begin
        noff = noff - len; // [R3]
      end
      idx_d = base_q[use_req.ptr] + noff[13:0];
    end
  end

  // only the presented address is reversed, the pointer keeps normal order
  always_comb begin
    addr_out = cur; // [R2]
    if (BITREV_OK && bitrev_en) begin
      for (int b = 0; b < `DOAG_AW; b++) begin
        addr_out[b] = cur[`DOAG_AW-1-b]; // [R5] [R13]
      end
    end
  end

  // software write wins over a hardware update of the same pointer
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < `DOAG_NPTR; i++) begin
        idx_q[i]  <= `DOAG_RST_WORD;
        base_q[i] <= `DOAG_RST_WORD;
      end
    end else begin
      if (use_req.valid) begin
        idx_q[use_req.ptr] <= idx_d; // [R1] [R2]
      end
      if (wr.en && wr.kind == `DOAG_KIND_IDX) begin
        idx_q[wr.idx]  <= wr.data;
        base_q[wr.idx] <= wr.data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < `DOAG_NPTR; i++) begin
        mod_q[i] <= `DOAG_RST_WORD;
        len_q[i] <= `DOAG_RST_WORD;
      end
    end else if (wr.en && wr.kind == `DOAG_KIND_MOD) begin
      mod_q[wr.idx] <= wr.data; // [R1]
    end else if (wr.en && wr.kind == `DOAG_KIND_LEN) begin
      len_q[wr.idx] <= wr.data; // [R1]
    end
  end

  always_comb begin
    case (rd_kind)
      `DOAG_KIND_IDX: rd_data = idx_q[rd_idx];
      `DOAG_KIND_MOD: rd_data = mod_q[rd_idx];
      `DOAG_KIND_LEN: rd_data = len_q[rd_idx];
      default:        rd_data = `DOAG_RST_WORD;
    endcase
  end

endmodule : doag_agen

// ===== doag_top.sv
// Operation
// R1: each generator keeps four index, four modify and four length registers
// R2: indirect access outputs the index, then adds the chosen modify register
// R3: a nonzero length wraps the post-modified pointer inside its circular buffer
// R4: serial port auto transfers use the same circular pointer logic
// R5: first generator addresses data memory only, with optional bit reversal
// R6: second generator drives program or data memory, never bit reversed
// R7: both generators work together, one data and one program operand per cycle
// R8: operand fetch and next instruction fetch complete in the same cycle
// R9: writes to program memory put the register high, extension byte low
// R10: data reads from program memory load the low byte into the extension
// R11: five separate buses: program addr, program data, data addr, data data, result
// R12: length zero means plain linear post-modify
// R13: bit reversal affects only the presented address, not the stored pointer
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`include "doag_map.svh"

module doag_top (
  input  wire logic                 clk,
  input  wire logic                 srst,
  // apb register port
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // operand requests from the sequencer and the serial port
  input  wire doag_pkg::doag_req_s  data_side_address_generator_req,
  input  wire doag_pkg::doag_req_s  dual_side_address_generator_req,
  input  wire logic                 dual_side_address_generator_to_pm,
  input  wire logic                 dm_write,
  input  wire logic                 pm_write,
  input  wire doag_pkg::doag_req_s  sport_req,
  output logic                      sport_gnt,
  // result bus from the computational units
  input  wire logic [15:0]          result_bus,
  // instruction fetch path
  input  wire doag_pkg::doag_addr_t instr_addr,
  input  wire logic [23:0]          pm_fetch_data,
  output doag_pkg::doag_addr_t      pm_fetch_addr,
  output logic [23:0]               instr_word,
  // data memory buses
  output doag_pkg::doag_addr_t      data_mem_addr_bus,
  output logic                      dm_addr_vld,
  output logic                      dm_we,
  output logic [15:0]               data_mem_data_bus,
  // program memory operand buses
  output doag_pkg::doag_addr_t      prog_mem_addr_bus,
  output logic                      pm_addr_vld,
  output logic                      pm_we,
  output logic [23:0]               prog_mem_data_bus,
  input  wire logic [23:0]          pm_rdata,
  // operand read back into a 16-bit register
  output logic [15:0]               reg_load,
  output logic                      reg_load_vld
);

  logic                 wr_stb;
  logic                 setup;
  logic                 gen_space;
  logic                 hit;
  logic                 bitrev_q;
  logic [7:0]           program_extension_reg_q;
  logic [31:0]          prdata_q;
  logic                 pslverr_q;
  doag_pkg::doag_wr_s   wr1;
  doag_pkg::doag_wr_s   wr2;
  doag_pkg::doag_req_s  gen1_use;
  doag_pkg::doag_req_s  gen2_use;
  doag_pkg::doag_addr_t gen1_addr;
  doag_pkg::doag_addr_t gen2_addr;
  doag_pkg::doag_addr_t gen1_rd;
  doag_pkg::doag_addr_t gen2_rd;
  doag_pkg::doag_addr_t dm_addr_q;
  doag_pkg::doag_addr_t pm_addr_q;
  doag_pkg::doag_addr_t fetch_addr_q;
  logic [23:0]          instr_q;
  logic                 dm_vld_q;
  logic                 dm_we_q;
  logic [15:0]          dm_data_q;
  logic                 pm_vld_q;
  logic                 pm_we_q;
  logic [23:0]          pm_data_q;
  logic                 pm_rd_pend_q;
  logic                 pm_rd_data_q;
  logic [15:0]          reg_load_q;
  logic                 reg_load_vld_q;
  logic                 dm_from_gen1;
  logic                 dm_from_gen2;
  logic                 pm_from_gen2;

  // apb decode; zero wait states, read data captured in the setup cycle
  assign setup     = psel && !penable;
  assign wr_stb    = psel && penable && pwrite;
  assign gen_space = !paddr[7] && !paddr[1] && !paddr[0] && paddr[5:4] != 2'h3;
  always_comb begin
    hit = gen_space;
    if (paddr == `DOAG_OFS_CTRL || paddr == `DOAG_OFS_PX || paddr == `DOAG_OFS_STAT) begin
      hit = 1'b1;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  always_comb begin
    wr1      = '0;
    wr1.kind = paddr[5:4];
    wr1.idx  = paddr[3:2];
    wr1.data = pwdata[13:0];
    wr2      = wr1;
    wr1.en   = wr_stb && gen_space && !paddr[6];
    wr2.en   = wr_stb && gen_space && paddr[6];
  end

  // error flag and read data both stand from one setup edge to the next
  always_ff @(posedge clk) begin
    if (srst) begin
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !hit;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      if (gen_space) begin
        prdata_q <= {18'h0_0000, paddr[6] ? gen2_rd : gen1_rd};
      end else if (paddr == `DOAG_OFS_CTRL) begin
        prdata_q <= {31'h0000_0000, bitrev_q};
      end else if (paddr == `DOAG_OFS_PX) begin
        prdata_q <= {24'h00_0000, program_extension_reg_q};
      end else if (paddr == `DOAG_OFS_STAT) begin
        prdata_q <= {2'h0, pm_addr_q, 2'h0, dm_addr_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bitrev_q <= 1'b0;
    end else if (wr_stb && paddr == `DOAG_OFS_CTRL) begin
      bitrev_q <= pwdata[`DOAG_CTRL_BREV];
    end
  end

  // the sequencer owns generator 1; the serial port gets it in idle cycles
  assign sport_gnt = sport_req.valid && !data_side_address_generator_req.valid; // [R4]
  always_comb begin
    gen1_use = data_side_address_generator_req;
    if (!data_side_address_generator_req.valid) begin
      gen1_use = sport_req; // [R4]
    end
  end
  // a dropped data access is no access, so its pointer must not move
  always_comb begin
    gen2_use = dual_side_address_generator_req;
    if (!dual_side_address_generator_to_pm && gen1_use.valid) begin
      gen2_use.valid = 1'b0; // [R2]
    end
  end

  doag_agen #(
    .BITREV_OK (1'b1)
  ) u_data_side_address_generator (
    .clk       (clk),
    .srst      (srst),
    .wr        (wr1),
    .use_req   (gen1_use),
    .bitrev_en (bitrev_q),
    .rd_kind   (paddr[5:4]),
    .rd_idx    (paddr[3:2]),
    .addr_out  (gen1_addr),
    .rd_data   (gen1_rd)
  ); // [R5]

  doag_agen #(
    .BITREV_OK (1'b0)
  ) u_dual_side_address_generator (
    .clk       (clk),
    .srst      (srst),
    .wr        (wr2),
    .use_req   (gen2_use),
    .bitrev_en (1'b0),
    .rd_kind   (paddr[5:4]),
    .rd_idx    (paddr[3:2]),
    .addr_out  (gen2_addr),
    .rd_data   (gen2_rd)
  ); // [R6]

  // generator 1 has priority on the data bus; generator 2 falls back to it
  assign dm_from_gen1 = gen1_use.valid; // [R5]
  assign dm_from_gen2 = gen2_use.valid && !dual_side_address_generator_to_pm && !gen1_use.valid; // [R6]
  assign pm_from_gen2 = gen2_use.valid && dual_side_address_generator_to_pm; // [R6] [R7]

  always_ff @(posedge clk) begin
    if (srst) begin
      dm_vld_q <= 1'b0;
      dm_we_q  <= 1'b0;
    end else begin
      dm_vld_q <= dm_from_gen1 || dm_from_gen2;
      dm_we_q  <= (dm_from_gen1 || dm_from_gen2) && dm_write;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dm_addr_q <= `DOAG_RST_WORD;
    end else if (dm_from_gen1) begin
      dm_addr_q <= gen1_addr; // [R7]
    end else if (dm_from_gen2) begin
      dm_addr_q <= gen2_addr;
    end
  end

  // write data only moves on a write, the bus keeps the last stored word
  always_ff @(posedge clk) begin
    if (srst) begin
      dm_data_q <= 16'h0000;
    end else if ((dm_from_gen1 || dm_from_gen2) && dm_write) begin
      dm_data_q <= result_bus; // [R11]
    end
  end

  // memory answers a cycle after the address, so the load waits one more stage
  always_ff @(posedge clk) begin
    if (srst) begin
      pm_vld_q     <= 1'b0;
      pm_we_q      <= 1'b0;
      pm_rd_pend_q <= 1'b0;
      pm_rd_data_q <= 1'b0;
    end else begin
      pm_vld_q     <= pm_from_gen2;
      pm_we_q      <= pm_from_gen2 && pm_write;
      pm_rd_pend_q <= pm_from_gen2 && !pm_write;
      pm_rd_data_q <= pm_rd_pend_q; // [R10]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pm_addr_q <= `DOAG_RST_WORD;
    end else if (pm_from_gen2) begin
      pm_addr_q <= gen2_addr; // [R7]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pm_data_q <= 24'h00_0000;
    end else if (pm_from_gen2 && pm_write) begin
      pm_data_q <= {result_bus, program_extension_reg_q}; // [R9]
    end
  end

  // separate fetch port so the instruction never waits for an operand
  always_ff @(posedge clk) begin
    if (srst) begin
      fetch_addr_q <= `DOAG_RST_WORD;
      instr_q      <= 24'h00_0000;
    end else begin
      fetch_addr_q <= instr_addr; // [R8]
      instr_q      <= pm_fetch_data; // [R8]
    end
  end

  // operand data arrives the cycle after its address; split into reg and extension
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_load_q     <= 16'h0000;
      reg_load_vld_q <= 1'b0;
    end else begin
      reg_load_vld_q <= pm_rd_data_q;
      if (pm_rd_data_q) begin
        reg_load_q <= pm_rdata[23:8]; // [R10]
      end
    end
  end

  // hardware load wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      program_extension_reg_q <= `DOAG_RST_PX;
    end else if (pm_rd_data_q) begin
      program_extension_reg_q <= pm_rdata[7:0]; // [R10]
    end else if (wr_stb && paddr == `DOAG_OFS_PX) begin
      program_extension_reg_q <= pwdata[7:0];
    end
  end

  // five independent buses, none shared
  assign data_mem_addr_bus = dm_addr_q; // [R11]
  assign dm_addr_vld       = dm_vld_q;
  assign dm_we             = dm_we_q;
  assign data_mem_data_bus = dm_data_q; // [R11]
  assign prog_mem_addr_bus = pm_addr_q; // [R11]
  assign pm_addr_vld       = pm_vld_q;
  assign pm_we             = pm_we_q;
  assign prog_mem_data_bus = pm_data_q; // [R11]
  assign pm_fetch_addr     = fetch_addr_q;
  assign instr_word        = instr_q;
  assign reg_load          = reg_load_q;
  assign reg_load_vld      = reg_load_vld_q;

endmodule : doag_top

// ===== doag_chk.sv
module doag_chk (
  input wire logic                clk,
  input wire logic                srst,
  input wire doag_pkg::doag_req_s data_side_address_generator_req,
  input wire doag_pkg::doag_req_s dual_side_address_generator_req,
  input wire logic                dual_side_address_generator_to_pm,
  input wire logic                dm_write,
  input wire logic                pm_write,
  input wire doag_pkg::doag_req_s sport_req,
  input wire logic                sport_gnt,
  input wire logic [15:0]         result_bus,
  input wire logic                dm_addr_vld,
  input wire logic                dm_we,
  input wire logic [15:0]         data_mem_data_bus,
  input wire logic                pm_addr_vld,
  input wire logic                pm_we,
  input wire logic [23:0]         prog_mem_data_bus,
  input wire logic [23:0]         pm_rdata,
  input wire logic [15:0]         reg_load,
  input wire logic                reg_load_vld
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire logic g2dm = dual_side_address_generator_req.valid && !dual_side_address_generator_to_pm;
  wire logic g2pm = dual_side_address_generator_req.valid && dual_side_address_generator_to_pm;
  sequence pm_rd_s;
    g2pm && !pm_write ##1 pm_addr_vld && !pm_we;
  endsequence
  sport_gnt_a: assert property (sport_gnt == (sport_req.valid && !data_side_address_generator_req.valid))
    else $error("sport grant wrong");
  dm_issue_a: assert property (data_side_address_generator_req.valid |=> dm_addr_vld)
    else $error("data access missing");
  dm_idle_a: assert property (!data_side_address_generator_req.valid && !sport_req.valid && !g2dm |=> !dm_addr_vld)
    else $error("data access unasked");
  pm_issue_a: assert property (g2pm |=> pm_addr_vld)
    else $error("program access missing");
  pm_idle_a: assert property (!g2pm |=> !pm_addr_vld)
    else $error("program access unasked");
  pm_word_a: assert property (g2pm && pm_write |=> pm_we && prog_mem_data_bus[23:8] == $past(result_bus))
    else $error("program write word wrong");
  pm_load_a: assert property (pm_rd_s |-> ##2 reg_load_vld && reg_load == $past(pm_rdata[23:8]))
    else $error("program read load wrong");
  dm_word_a: assert property (data_side_address_generator_req.valid && dm_write |=> dm_we && data_mem_data_bus == $past(result_bus))
    else $error("data write word wrong");
endmodule : doag_chk

// ===== doag_pmem.sv
module doag_pmem (
  input  wire logic                 clk,
  input  wire logic                 pm_addr_vld,
  input  wire logic                 pm_we,
  input  wire doag_pkg::doag_addr_t prog_mem_addr_bus,
  input  wire logic [23:0]          prog_mem_data_bus,
  input  wire doag_pkg::doag_addr_t pm_fetch_addr,
  output logic [23:0]               pm_rdata,
  output logic [23:0]               pm_fetch_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // only 64 words: higher addresses alias, enough for short tests
  logic [23:0] mem [64];
  initial begin
    pm_rdata = 24'h0;
    for (int i = 0; i < 64; i++) begin
      mem[i] = {8'h5a, 16'(i)};
    end
  end
  // data flips outside its one valid cycle so a late sample is caught
  always @(posedge clk) begin
    if (pm_addr_vld && pm_we) begin
      mem[prog_mem_addr_bus[5:0]] <= prog_mem_data_bus;
    end
    pm_rdata <= (pm_addr_vld && !pm_we) ? mem[prog_mem_addr_bus[5:0]] : ~pm_rdata;
  end
  assign pm_fetch_data = mem[pm_fetch_addr[5:0]];
endmodule : doag_pmem

// ===== dual_operand_address_generator_tb.sv
module dual_operand_address_generator_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [4:0] a; logic [4:0] b; doag_pkg::doag_addr_t e;} doag_row_s;
  logic                 clk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic                 dual_side_address_generator_to_pm = 1'h0, dm_write = 1'h0, pm_write = 1'h0, err, gnt;
  logic                 pready, pslverr, sport_gnt, dm_addr_vld, dm_we, pm_addr_vld, pm_we;
  logic                 reg_load_vld;
  logic [7:0]           paddr = 8'h0;
  logic [31:0]          pwdata = 32'h0, prdata, rd;
  doag_pkg::doag_req_s  data_side_address_generator_req = 5'h0, dual_side_address_generator_req = 5'h0, sport_req = 5'h0;
  logic [15:0]          result_bus = 16'h0, data_mem_data_bus, reg_load;
  doag_pkg::doag_addr_t instr_addr = 14'h0, pm_fetch_addr, data_mem_addr_bus, prog_mem_addr_bus;
  logic [23:0]          pm_fetch_data, instr_word, prog_mem_data_bus, pm_rdata;
  int                   mismatches = 0, samples_checked = 0;
  logic [39:0]          cfg [10] = '{40'h00_00000010, 40'h10_00000002, 40'h04_00000020,
    40'h14_00000003, 40'h24_00000004, 40'h18_00003fff, 40'h40_00000030, 40'h50_00000001,
    40'h44_00000033, 40'h84_000000ab};
  doag_row_s            rows [10] = '{'{5'h10, 5'h00, 14'h0010}, '{5'h10, 5'h00, 14'h0012},
    '{5'h15, 5'h00, 14'h0020}, '{5'h15, 5'h00, 14'h0023}, '{5'h15, 5'h00, 14'h0022},
    '{5'h15, 5'h00, 14'h0021}, '{5'h1a, 5'h00, 14'h0000}, '{5'h1a, 5'h00, 14'h3fff},
    '{5'h00, 5'h10, 14'h0030}, '{5'h00, 5'h10, 14'h0031}};
  always #20 clk = ~clk;
  doag_top DUT (.*);
  doag_pmem PM (.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic op(input logic [4:0] a, input logic [4:0] b, input logic [4:0] s,
                    input logic tp, input logic w);
    @(posedge clk);
    {data_side_address_generator_req, dual_side_address_generator_req, sport_req, dual_side_address_generator_to_pm, dm_write, pm_write} <= {a, b, s, tp, w, w};
    @(negedge clk);
    gnt = sport_gnt;
    @(posedge clk);
    {data_side_address_generator_req, dual_side_address_generator_req, sport_req, dm_write, pm_write} <= 17'h0;
    @(negedge clk);
  endtask : op
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    @(negedge clk);
    chk({dm_addr_vld, pm_addr_vld, reg_load_vld, dm_we, pm_we}, 32'h0);
    foreach (cfg[i]) apb(1'h1, cfg[i][39:32], cfg[i][31:0]);
    apb(1'h0, 8'h14, 32'h0);
    chk(rd, 32'h3);
    apb(1'h0, 8'hfc, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    foreach (rows[i]) begin
      op(rows[i].a, rows[i].b, 5'h0, 1'h0, 1'h0);
      chk(data_mem_addr_bus, rows[i].e);
    end
    apb(1'h1, 8'h80, 32'h1);
    op(5'h10, 5'h0, 5'h0, 1'h0, 1'h0);
    chk(data_mem_addr_bus, 14'h0a00);
    op(5'h0, 5'h10, 5'h0, 1'h0, 1'h0);
    chk(data_mem_addr_bus, 14'h0032);
    apb(1'h1, 8'h80, 32'h0);
    op(5'h10, 5'h0, 5'h0, 1'h0, 1'h0);
    chk(data_mem_addr_bus, 14'h0016);
    @(posedge clk);
    result_bus <= 16'h1234;
    op(5'h10, 5'h10, 5'h0, 1'h1, 1'h1);
    chk({dm_addr_vld, pm_addr_vld, dm_we, pm_we, 2'h0, data_mem_addr_bus}, 32'hf0018);
    chk({prog_mem_data_bus, prog_mem_addr_bus[7:0]}, 32'h1234ab33);
    chk(data_mem_data_bus, 32'h1234);
    // clear the extension first so the read must reload it
    apb(1'h1, 8'h84, 32'h0);
    op(5'h0, 5'h15, 5'h0, 1'h1, 1'h0);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({reg_load_vld, reg_load}, 32'h11234);
    apb(1'h0, 8'h84, 32'h0);
    chk(rd, 32'hab);
    op(5'h10, 5'h0, 5'h15, 1'h0, 1'h0);
    chk(gnt, 32'h0);
    op(5'h0, 5'h0, 5'h15, 1'h0, 1'h0);
    chk({gnt, data_mem_addr_bus}, 32'h4020);
    op(5'h0, 5'h0, 5'h15, 1'h0, 1'h0);
    chk({gnt, data_mem_addr_bus}, 32'h4023);
    @(posedge clk);
    instr_addr <= 14'h5;
    op(5'h0, 5'h15, 5'h0, 1'h1, 1'h0);
    chk({pm_addr_vld, pm_fetch_addr[6:0], instr_word}, 32'h855a0005);
    @(posedge clk);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    @(negedge clk);
    chk({dm_addr_vld, pm_addr_vld, reg_load_vld, prog_mem_addr_bus}, 32'h0);
    apb(1'h0, 8'h44, 32'h0);
    chk(rd, 32'h0);
    print_verdict;
  end
endmodule : dual_operand_address_generator_tb
bind doag_top doag_chk u_chk (.*);
